// ===== logic/gpr_top.sv
// Implementation choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "gpr_params.svh"
module gpr_top
    import gpr_pkg::*;
#(
    parameter int          NUM_PORTS        = 16,
    parameter bit          AFFECTED_VARIANT = 1'b1,
    parameter logic [15:0] ANALOG_PORTS     = `GPR_ANALOG_PORTS,
    parameter logic [15:0] DIGITAL_PDISC    = 16'h0000
) (
    // Clock and reset
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    // AHB-Lite register bus
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [3:0]              hprot,
    input  wire logic                    hready,
    input  wire logic [31:0]             hwdata,
    output logic      [31:0]             hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    // Pads
    input  wire logic [NUM_PORTS*16-1:0] pin_in,
    output logic      [NUM_PORTS*16-1:0] pad_input_disable,
    output logic      [NUM_PORTS*32-1:0] pad_input_control_upper,
    output logic      [NUM_PORTS*64-1:0] pad_driver,
    // Interrupt
    output logic                         irq
);
    gpr_reg_if rif ();

    gpr_word_type iocr_reg  [NUM_PORTS];
    gpr_pins_type pdisc_reg [NUM_PORTS];
    gpr_word_type pdr0_reg  [NUM_PORTS];
    gpr_word_type pdr1_reg  [NUM_PORTS];
    gpr_pins_type level     [NUM_PORTS];

    logic                      mod_rst_reg;
    logic [`GPR_TRAP_WIDTH-1:0] trap_set;
    logic [`GPR_TRAP_WIDTH-1:0] trap_raw_reg;
    logic [`GPR_TRAP_WIDTH-1:0] trap_mask_reg;
    logic                      port_hit;
    logic                      global_hit;
    logic [3:0]                port_sel;
    logic [7:0]                offs;
    logic                      cfg_wr;
    logic                      drv_wr;
    logic                      locked_drv_wr;
    gpr_word_type              rdata_next;
    // Held as a parameter so that single bits can be selected from it
    localparam logic [15:0]    LOCKED_PORTS = `GPR_PDR_LOCKED_PORTS;

    //////////////////////////////////////////////////////////////////////////
    // Bus slave

    gpr_ahb_slave u_slave (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hprot     (hprot),
        .hready    (hready),
        .hwdata    (hwdata),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .rif       (rif.slave)
    );

    //////////////////////////////////////////////////////////////////////////
    // Address decode

    assign port_sel   = rif.addr[`GPR_PORT_SHIFT+3:`GPR_PORT_SHIFT];
    assign offs       = rif.addr[7:0];
    assign port_hit   = (rif.addr[31:12] == 20'h00000)
                        && (32'(port_sel) < NUM_PORTS);
    assign global_hit = (rif.addr[31:8] == `GPR_GLOBAL_BASE >> 8);

    // Config registers; input level is read-only and not counted
    assign cfg_wr = rif.wr_en && port_hit
                    && (offs == `GPR_OFS_IOCR_UPPER
                        || offs == `GPR_OFS_IN_DISABLE
                        || offs == `GPR_OFS_DRV_LOW
                        || offs == `GPR_OFS_DRV_HIGH);
    assign drv_wr = rif.wr_en && port_hit
                    && (offs == `GPR_OFS_DRV_LOW || offs == `GPR_OFS_DRV_HIGH);
    assign locked_drv_wr = drv_wr && LOCKED_PORTS[port_sel]; // RULE_12

    //////////////////////////////////////////////////////////////////////////
    // Module reset request, self clearing after one cycle

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mod_rst_reg <= 1'b0;
        end else begin
            mod_rst_reg <= rif.wr_en && global_hit && offs == `GPR_OFS_CTRL
                           && rif.priv && rif.wdata[`GPR_CTRL_MODRST_BIT]; // RULE_04
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Port registers

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        localparam bit          ANALOG = ANALOG_PORTS[p];
        localparam bit          LOCKED = LOCKED_PORTS[p];
        localparam logic [15:0] FIXED0 = (p == `GPR_P15_INDEX)
                                         ? `GPR_P15_LOCK_MASK : 16'h0000;
        localparam logic [15:0] PDISC_SYS = ANALOG
                                            ? (`GPR_PDISC_ANALOG_SYS & ~FIXED0)
                                            : DIGITAL_PDISC;
        localparam logic [31:0] IOCR_MOD = AFFECTED_VARIANT
                                           ? `GPR_IOCR_MOD_RST : `GPR_IOCR_SYS_RST;
        logic sel_wr;

        // Unprivileged writes are dropped here and flagged below
        assign sel_wr = rif.wr_en && port_hit && rif.priv // RULE_09
                        && (32'(port_sel) == p);

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                iocr_reg[p] <= `GPR_IOCR_SYS_RST;
            end else if (mod_rst_reg) begin
                iocr_reg[p] <= IOCR_MOD; // RULE_07
            end else if (sel_wr && offs == `GPR_OFS_IOCR_UPPER) begin
                iocr_reg[p] <= rif.wdata;
            end
        end

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                pdisc_reg[p] <= PDISC_SYS;
            end else if (mod_rst_reg) begin
                pdisc_reg[p] <= `GPR_PDISC_MOD_RST; // RULE_05
            end else if (ANALOG && sel_wr && offs == `GPR_OFS_IN_DISABLE) begin
                // Digital ports never take this branch
                pdisc_reg[p] <= rif.wdata[15:0] & ~FIXED0; // RULE_01 RULE_08 RULE_13
            end
        end

        // Locked driver registers are constants, so no reset can lower them
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                pdr0_reg[p] <= `GPR_PDR_SYS_RST; // RULE_06
                pdr1_reg[p] <= `GPR_PDR_SYS_RST;
            end else if (LOCKED) begin
                pdr0_reg[p] <= `GPR_PDR_SYS_RST; // RULE_11
                pdr1_reg[p] <= `GPR_PDR_SYS_RST;
            end else if (mod_rst_reg) begin
                pdr0_reg[p] <= `GPR_PDR_MOD_RST; // RULE_06
                pdr1_reg[p] <= `GPR_PDR_MOD_RST;
            end else if (sel_wr && offs == `GPR_OFS_DRV_LOW) begin
                pdr0_reg[p] <= rif.wdata; // RULE_10
            end else if (sel_wr && offs == `GPR_OFS_DRV_HIGH) begin
                pdr1_reg[p] <= rif.wdata; // RULE_10
            end
        end

        // Pins 4 and 5 of port 15 pass the raw analog-driven pad level
        assign level[p] = pin_in[p*16 +: 16] & ~pdisc_reg[p]; // RULE_02 RULE_03

        assign pad_input_disable[p*16 +: 16]       = pdisc_reg[p];
        assign pad_input_control_upper[p*32 +: 32] = iocr_reg[p];
        assign pad_driver[p*64 +: 64]              = {pdr1_reg[p], pdr0_reg[p]};
    end

    //////////////////////////////////////////////////////////////////////////
    // Trap status and interrupt

    always_comb begin
        trap_set = '0;
        trap_set[`GPR_TRAP_BRIDGE1_BIT] = locked_drv_wr; // RULE_12
        trap_set[`GPR_TRAP_PRIV_BIT]    = cfg_wr && !rif.priv;
        trap_set[`GPR_TRAP_MODRST_BIT]  = mod_rst_reg;
    end

    gpr_event_status #(
        .WIDTH (`GPR_TRAP_WIDTH)
    ) u_trap (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .set_pulse  (trap_set),
        .clr_wr     (rif.wr_en && global_hit && offs == `GPR_OFS_TRAP_RAW),
        .mask_wr    (rif.wr_en && global_hit && offs == `GPR_OFS_TRAP_MASK),
        .wdata      (rif.wdata[`GPR_TRAP_WIDTH-1:0]),
        .status_reg (trap_raw_reg),
        .mask_reg   (trap_mask_reg),
        .irq        (irq)
    );

    //////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped addresses read as zero

    always_comb begin
        rdata_next = 32'h0000_0000;
        if (port_hit) begin
            unique case (offs)
                `GPR_OFS_IOCR_UPPER: rdata_next = iocr_reg[port_sel];
                `GPR_OFS_IN_DISABLE: rdata_next = {16'h0000, pdisc_reg[port_sel]};
                `GPR_OFS_DRV_LOW:    rdata_next = pdr0_reg[port_sel];
                `GPR_OFS_DRV_HIGH:   rdata_next = pdr1_reg[port_sel];
                `GPR_OFS_IN_LEVEL:   rdata_next = {16'h0000, level[port_sel]};
                default:             rdata_next = 32'h0000_0000;
            endcase
        end else if (global_hit) begin
            unique case (offs)
                `GPR_OFS_TRAP_RAW:  rdata_next = 32'(trap_raw_reg);
                `GPR_OFS_TRAP_MASK: rdata_next = 32'(trap_mask_reg);
                default:            rdata_next = 32'h0000_0000;
            endcase
        end
    end

    assign rif.rdata = rdata_next;

    //////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic p15_dis_wr;
    logic p0_dis_wr;
    logic p0_iocr_user_wr;

    assign p15_dis_wr = rif.wr_en && port_hit && rif.priv
                        && 32'(port_sel) == `GPR_P15_INDEX
                        && offs == `GPR_OFS_IN_DISABLE;
    assign p0_dis_wr = rif.wr_en && port_hit && port_sel == 4'h0
                       && offs == `GPR_OFS_IN_DISABLE;
    assign p0_iocr_user_wr = rif.wr_en && port_hit && !rif.priv
                             && port_sel == 4'h0 && offs == `GPR_OFS_IOCR_UPPER;

    sequence s_modrst_req;
        rif.wr_en && global_hit && offs == `GPR_OFS_CTRL && rif.priv
        && rif.wdata[`GPR_CTRL_MODRST_BIT];
    endsequence

    sequence s_modrst_pulse;
        mod_rst_reg ##1 !mod_rst_reg;
    endsequence

    property p_p15_write_masked;
        p15_dis_wr && !mod_rst_reg |=>
            pdisc_reg[`GPR_P15_INDEX]
            == ($past(rif.wdata[15:0]) & ~`GPR_P15_LOCK_MASK);
    endproperty
    a_p15_write_masked: assert property (p_p15_write_masked) // RULE_01 RULE_13
        else $error("port 15 disable write not masked correctly");

    property p_p15_path_enabled;
        pad_input_disable[`GPR_P15_INDEX*16+4 +: 2] == 2'b00;
    endproperty
    a_p15_path_enabled: assert property (p_p15_path_enabled) // RULE_02
        else $error("port 15 pins 4 and 5 digital path disabled");

    property p_p15_level_follows_pin;
        level[`GPR_P15_INDEX][5:4] == pin_in[`GPR_P15_INDEX*16+4 +: 2];
    endproperty
    a_p15_level_follows_pin: assert property (p_p15_level_follows_pin) // RULE_03
        else $error("port 15 level bits do not follow pins");

    property p_modrst_seq;
        s_modrst_req |=> s_modrst_pulse;
    endproperty
    a_modrst_seq: assert property (p_modrst_seq) // RULE_04
        else $error("module reset request did not give one pulse");

    property p_modrst_values;
        mod_rst_reg |=> pdisc_reg[0] == `GPR_PDISC_MOD_RST
                        && pdr0_reg[0] == `GPR_PDR_MOD_RST
                        && pdr1_reg[0] == `GPR_PDR_MOD_RST;
    endproperty
    a_modrst_values: assert property (p_modrst_values) // RULE_05 RULE_06
        else $error("port 0 module reset values wrong");

    property p_modrst_iocr;
        mod_rst_reg |=> iocr_reg[0]
            == (AFFECTED_VARIANT ? `GPR_IOCR_MOD_RST : `GPR_IOCR_SYS_RST);
    endproperty
    a_modrst_iocr: assert property (p_modrst_iocr) // RULE_07
        else $error("upper input control module reset value wrong");

    property p_digital_pdisc_ro;
        p0_dis_wr && !mod_rst_reg && !ANALOG_PORTS[0] |=> $stable(pdisc_reg[0]);
    endproperty
    a_digital_pdisc_ro: assert property (p_digital_pdisc_ro) // RULE_08
        else $error("digital port disable register changed by write");

    property p_user_write_dropped;
        p0_iocr_user_wr && !mod_rst_reg |=> $stable(iocr_reg[0])
                                            && trap_raw_reg[`GPR_TRAP_PRIV_BIT];
    endproperty
    a_user_write_dropped: assert property (p_user_write_dropped) // RULE_09
        else $error("unprivileged write took effect or was not flagged");

    property p_locked_drv_const;
        pdr0_reg[7] == `GPR_PDR_SYS_RST && pdr1_reg[9] == `GPR_PDR_SYS_RST;
    endproperty
    a_locked_drv_const: assert property (p_locked_drv_const) // RULE_11
        else $error("locked driver register lost its strong-soft value");

    property p_locked_drv_trap;
        locked_drv_wr |=> trap_raw_reg[`GPR_TRAP_BRIDGE1_BIT][*2];
    endproperty
    a_locked_drv_trap: assert property (p_locked_drv_trap) // RULE_12
        else $error("locked driver write did not raise the trap");

    property p_write_no_stall;
        rif.wr_en |-> hreadyout;
    endproperty
    a_write_no_stall: assert property (p_write_no_stall) // RULE_13
        else $error("write data phase stalled");

    property p_wait_bounded;
        !hreadyout |=> hreadyout;
    endproperty
    a_wait_bounded: assert property (p_wait_bounded) // RULE_13
        else $error("bus held in wait for more than one cycle");

    property p_bus_okay;
        hresp == 1'b0;
    endproperty
    a_bus_okay: assert property (p_bus_okay) // RULE_13
        else $error("slave answered with an error response");

    property p_modrst_locked_drv;
        mod_rst_reg |=> pdr0_reg[8] == `GPR_PDR_SYS_RST && pdr1_reg[8] == `GPR_PDR_SYS_RST;
    endproperty
    a_modrst_locked_drv: assert property (p_modrst_locked_drv) // RULE_11
        else $error("locked driver register lowered by module reset");

    property p_modrst_analog_enabled;
        mod_rst_reg |=> pdisc_reg[`GPR_P15_INDEX] == `GPR_PDISC_MOD_RST
                        && pdisc_reg[14] == `GPR_PDISC_MOD_RST;
    endproperty
    a_modrst_analog_enabled: assert property (p_modrst_analog_enabled) // RULE_05
        else $error("analog port digital path still disabled after module reset");
endmodule : gpr_top

// ===== logic/gpr_params.svh
// Summary of operation
// (RULE_01) Port 15 input-disable bits 4 and 5 ignore writes and read as 0.
// (RULE_02) Port 15 pins 4 and 5 keep their digital input path enabled.
// (RULE_03) Port 15 input level bits 4 and 5 follow the analog pin level.
// (RULE_04) A module reset request resets port registers without a system reset.
// (RULE_05) Module reset clears every input-disable register to zero.
// (RULE_06) Driver registers: strong-soft after system reset, zero after module reset except ports 7, 8, 9.
// (RULE_07) Affected variant: upper input control takes 2020_2020 on module reset.
// (RULE_08) Input-disable register of a purely digital port is read-only.
// (RULE_09) Control, disable and driver settings are written only in privileged mode.
// (RULE_10) Every pin has its own driver-strength field in its port driver register.
// (RULE_11) Driver registers of ports 7, 8, 9 ignore writes, stay strong-soft.
// (RULE_12) A write to a locked driver register sets the bridge 1 trap request.
// (RULE_13) Locked bits leave other bits writable and never stall the bus.
`ifndef GPR_PARAMS_SVH
`define GPR_PARAMS_SVH

`define GPR_PORT_SHIFT 8
`define GPR_OFS_IOCR_UPPER 8'h00
`define GPR_OFS_IN_DISABLE 8'h04
`define GPR_OFS_DRV_LOW 8'h08
`define GPR_OFS_DRV_HIGH 8'h0C
`define GPR_OFS_IN_LEVEL 8'h10
`define GPR_GLOBAL_BASE 32'h0000_1000
`define GPR_OFS_CTRL 8'h00
`define GPR_OFS_TRAP_RAW 8'h04
`define GPR_OFS_TRAP_MASK 8'h08
`define GPR_CTRL_MODRST_BIT 0
`define GPR_TRAP_BRIDGE1_BIT 0
`define GPR_TRAP_PRIV_BIT 1
`define GPR_TRAP_MODRST_BIT 2
`define GPR_TRAP_WIDTH 3
`define GPR_IOCR_SYS_RST 32'h0000_0000
`define GPR_IOCR_MOD_RST 32'h2020_2020
`define GPR_PDISC_MOD_RST 16'h0000
`define GPR_PDISC_ANALOG_SYS 16'hFFFF
`define GPR_PDR_SYS_RST 32'h2222_2222
`define GPR_PDR_MOD_RST 32'h0000_0000
`define GPR_P15_INDEX 15
`define GPR_P15_LOCK_MASK 16'h0030
`define GPR_PDR_LOCKED_PORTS 16'h0380
`define GPR_ANALOG_PORTS 16'hC000

`endif

// ===== logic/gpr_pkg.sv
package gpr_pkg;
    typedef logic [31:0] gpr_word_type;
    typedef logic [15:0] gpr_pins_type;
    typedef enum logic [1:0] {
        GPR_IDLE,
        GPR_WRITE,
        GPR_READ,
        GPR_READ_DONE
    } gpr_slv_state_type;
endpackage : gpr_pkg

// ===== logic/gpr_reg_if.sv
`timescale 1ns/1ps
interface gpr_reg_if;
    import gpr_pkg::*;
    logic         wr_en;
    gpr_word_type addr;
    gpr_word_type wdata;
    logic         priv;
    gpr_word_type rdata;
    modport slave (output wr_en, output addr, output wdata, output priv, input rdata);
    modport regs  (input wr_en, input addr, input wdata, input priv, output rdata);
endinterface : gpr_reg_if

// ===== logic/gpr_ahb_slave.sv
`timescale 1ns/1ps
module gpr_ahb_slave
    import gpr_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave side
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [3:0]  hprot,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Register side
    gpr_reg_if.slave         rif
);
    gpr_slv_state_type state_reg;
    gpr_word_type      addr_reg;
    logic              priv_reg;
    logic              accept;

    // Only whole-word transfers are issued, so hsize is not decoded
    assign accept = hsel && htrans[1] && hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= GPR_IDLE;
        end else begin
            unique case (state_reg)
                GPR_READ:  state_reg <= GPR_READ_DONE;
                GPR_IDLE, GPR_WRITE, GPR_READ_DONE: begin
                    if (accept) begin
                        state_reg <= hwrite ? GPR_WRITE : GPR_READ;
                    end else begin
                        state_reg <= GPR_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_reg <= 32'h0000_0000;
            priv_reg <= 1'b0;
        end else if (accept) begin
            addr_reg <= haddr;
            priv_reg <= hprot[1];
        end
    end

    // One wait state on reads lets hrdata come from a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (state_reg == GPR_READ) begin
            hrdata <= rif.rdata;
        end
    end

    assign hreadyout = (state_reg != GPR_READ); // RULE_13
    assign hresp     = 1'b0;
    assign rif.wr_en = (state_reg == GPR_WRITE);
    assign rif.addr  = addr_reg;
    assign rif.wdata = hwdata;
    assign rif.priv  = priv_reg;
endmodule : gpr_ahb_slave

// ===== logic/gpr_event_status.sv
`timescale 1ns/1ps
module gpr_event_status #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // Events and software access
    input  wire logic [WIDTH-1:0] set_pulse,
    input  wire logic             clr_wr,
    input  wire logic             mask_wr,
    input  wire logic [WIDTH-1:0] wdata,
    // State
    output logic      [WIDTH-1:0] status_reg,
    output logic      [WIDTH-1:0] mask_reg,
    output logic                  irq
);
    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_reg <= '0;
        end else begin
            status_reg <= (status_reg & ~(clr_wr ? wdata : '0)) | set_pulse;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_reg <= '0;
        end else if (mask_wr) begin
            mask_reg <= wdata;
        end
    end

    assign irq = |(status_reg & mask_reg);
endmodule : gpr_event_status

// ===== tb/gpr_pin_model.sv
`timescale 1ns/1ps
module gpr_pin_model #(
    parameter int NUM_PORTS = 16
) (
    // Levels set by the bench
    input  wire logic [15:0]             level,
    // Pads as seen by the device
    output logic      [NUM_PORTS*16-1:0] pin_in
);
    // Every port sees the same pattern; port 15 bits 4,5 stand for analog levels
    assign pin_in = {NUM_PORTS{level}};
endmodule : gpr_pin_model

// ===== tb/port_pad_config_resets_tb.sv
`timescale 1ns/1ps
`include "gpr_params.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module port_pad_config_resets_tb;
    import gpr_pkg::*;
    logic         hclk, hresetn, hsel, hwrite, hresp, hreadyout, irq;
    logic [1:0]   htrans;
    logic [2:0]   hsize;
    logic [3:0]   hprot;
    logic [31:0]  haddr, hwdata, hrdata, q;
    logic [15:0]  level;
    logic [255:0] pin_in, pdis;
    logic [511:0] picu;
    logic [1023:0] pdrv;
    int           errors, check_count;
    gpr_pin_model #(.NUM_PORTS(16)) gpr_pin_model_i (.level(level), .pin_in(pin_in));
    gpr_top gpr_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hprot(hprot),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .pin_in(pin_in), .pad_input_disable(pdis),
        .pad_input_control_upper(picu), .pad_driver(pdrv), .irq(irq));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    function automatic logic [31:0] pa(input int p, input logic [7:0] ofs);
        return (32'(p) << `GPR_PORT_SHIFT) + 32'(ofs);
    endfunction : pa
    // Ready sampled before the edge so the edge's own updates never race the check
    task automatic wait_rdy();
        logic r;
        int   n;
        n = 0;
        do begin
            @(negedge hclk);
            r = hreadyout;
            q = hrdata;
            @(posedge hclk);
            n++;
        end while (r !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            conclude();
        end
    endtask : wait_rdy
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       input logic pr);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= wr;
        hprot  <= {2'b00, pr, 1'b1};
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
    endtask : bus
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 1'b1);
    endtask : wr
    task automatic rd(input logic [31:0] a);
        bus(1'b0, a, 32'h0000_0000, 1'b1);
    endtask : rd
    task automatic chk_irq(input logic e);
        @(negedge hclk);
        `CHK(irq, e)
        @(posedge hclk);
    endtask : chk_irq
    task automatic conclude();
        $display("checks=%0d errors=%0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #50us;
        errors++;
        conclude();
    end
    initial begin
        errors = 0;
        check_count = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hprot = 4'h3;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        level = 16'h0030;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // System reset values of every port
        for (int p = 0; p < 16; p++) begin
            rd(pa(p, `GPR_OFS_IOCR_UPPER));
            `CHK(q, `GPR_IOCR_SYS_RST)
            rd(pa(p, `GPR_OFS_DRV_LOW));
            `CHK(q, `GPR_PDR_SYS_RST)
            rd(pa(p, `GPR_OFS_DRV_HIGH));
            `CHK(q, `GPR_PDR_SYS_RST)
            rd(pa(p, `GPR_OFS_IN_DISABLE));
            `CHK(q, (p == 15) ? 32'h0000_FFCF : (p == 14) ? 32'h0000_FFFF : 32'h0)
        end
        // Locked bits of port 15 while the rest still writes
        wr(pa(15, `GPR_OFS_IN_DISABLE), 32'h0000_FFF0);
        rd(pa(15, `GPR_OFS_IN_DISABLE));
        `CHK(q, 32'h0000_FFC0)
        rd(pa(15, `GPR_OFS_IN_LEVEL));
        `CHK(q, 32'h0000_0030)
        `CHK(pdis[15*16+:16], 16'hFFC0)
        // Digital port disable register is read-only
        wr(pa(0, `GPR_OFS_IN_DISABLE), 32'h0000_FFFF);
        rd(pa(0, `GPR_OFS_IN_DISABLE));
        `CHK(q, 32'h0000_0000)
        // Per-pin driver fields of a free port
        wr(pa(2, `GPR_OFS_DRV_LOW), 32'h1234_5678);
        rd(pa(2, `GPR_OFS_DRV_LOW));
        `CHK(q, 32'h1234_5678)
        `CHK(pdrv[2*64+:32], 32'h1234_5678)
        // Locked driver registers of ports 7, 8, 9 and the trap they raise
        for (int p = 7; p < 10; p++) begin
            wr(pa(p, `GPR_OFS_DRV_HIGH), 32'h0000_0000);
            rd(pa(p, `GPR_OFS_DRV_HIGH));
            `CHK(q, `GPR_PDR_SYS_RST)
        end
        // Unprivileged write must not land
        bus(1'b1, pa(0, `GPR_OFS_IOCR_UPPER), 32'hFFFF_FFFF, 1'b0);
        rd(pa(0, `GPR_OFS_IOCR_UPPER));
        `CHK(q, 32'h0000_0000)
        rd(`GPR_GLOBAL_BASE + `GPR_OFS_TRAP_RAW);
        `CHK(q, 32'h0000_0003)
        chk_irq(1'b0);
        wr(`GPR_GLOBAL_BASE + `GPR_OFS_TRAP_MASK, 32'h0000_0001);
        chk_irq(1'b1);
        wr(`GPR_GLOBAL_BASE + `GPR_OFS_TRAP_RAW, 32'h0000_0003);
        chk_irq(1'b0);
        // Unmapped place reads zero
        wr(32'h0000_2000, 32'hFFFF_FFFF);
        rd(32'h0000_2000);
        `CHK(q, 32'h0000_0000)
        `CHK(hresp, 1'b0)
        // Module reset gives its own values
        level <= 16'hA5A5;
        wr(`GPR_GLOBAL_BASE + `GPR_OFS_CTRL, 32'h0000_0001);
        repeat (3) @(posedge hclk);
        rd(pa(0, `GPR_OFS_IOCR_UPPER));
        `CHK(q, `GPR_IOCR_MOD_RST)
        `CHK(picu[5*32+:32], `GPR_IOCR_MOD_RST)
        rd(pa(14, `GPR_OFS_IN_DISABLE));
        `CHK(q, 32'h0000_0000)
        rd(pa(15, `GPR_OFS_IN_LEVEL));
        `CHK(q, 32'h0000_A5A5)
        rd(pa(2, `GPR_OFS_DRV_LOW));
        `CHK(q, `GPR_PDR_MOD_RST)
        `CHK(pdrv[8*64+:64], {2{`GPR_PDR_SYS_RST}})
        rd(`GPR_GLOBAL_BASE + `GPR_OFS_TRAP_RAW);
        `CHK(q, 32'h0000_0004)
        conclude();
    end
endmodule : port_pad_config_resets_tb
